// *** core/rft_dev.sv ***
`default_nettype none
// Summary of operation
// - one fifo address, rw bit selects fifo
// - tx fifo write only, rx fifo read only
// - single access: header, one byte, header
// - burst runs until chip select rises
// - four fifo header codes decoded
// - write status shows free space before byte
// - flush strobes only in idle or error states
// - sleep entry empties both fifos
// - table at own address, eight bytes
// - eight entries picked by power level
// - index increments, clears on select high, wraps
// - table burst and direction from header
// - host deselects before single readback
// - sleep keeps only table entry zero
// - output pin tristate unless SO_GENERAL_ENABLE, serial out when selected
// - pin levels latched on select falling
// - clock/data pairs decode to four strobes
// - pin control only changes state
// - power down waits for select high
// - select low wakes sleep into idle
// - output zero is serial input in transmit when SERIAL_MODE is set
// - status count saturates at fifteen
// - overrun 110, underrun 111, flush clears
module rft_dev
    import rft_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // serial link
    rft_link_if.dev LINK,
    // configuration
    input wire logic PIN_CONTROL_ENABLE,
    input wire logic SO_GENERAL_ENABLE,
    input wire logic SO_GENERAL_LEVEL,
    input wire logic SERIAL_MODE,
    input wire logic GEN0_LEVEL,
    input wire logic [2:0] POWER_LEVEL_SELECT,
    // modem side
    input wire logic TX_POP,
    input wire logic RX_PUSH,
    input wire logic [7:0] RX_DATA,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    output logic [7:0] PA_SETTING,
    output logic [2:0] RADIO_STATE,
    output logic SERIAL_TX_DATA
);
    typedef struct packed {
        logic cs_s1, cs_s2, cs_q, ck_s1, ck_s2, ck_q, si_s1, si_s2, g0_s1, g0_s2;
        rft_mode_t mode;
        logic burst;
        logic hdr_rw;
        logic [2:0] bit_cnt;
        logic [7:0] sin;
        logic [7:0] sout;
        logic load_pend;
        logic [RFT_FIFO_DEPTH-1:0][7:0] tx_mem;
        logic [RFT_FIFO_AW-1:0] tx_wr, tx_rd;
        logic [RFT_FIFO_AW:0] tx_cnt;
        logic [RFT_FIFO_DEPTH-1:0][7:0] rx_mem;
        logic [RFT_FIFO_AW-1:0] rx_wr, rx_rd;
        logic [RFT_FIFO_AW:0] rx_cnt;
        logic [7:0][7:0] power_amp_table;
        logic [RFT_TABLE_AW-1:0] idx;
        rft_radio_t radio;
        logic pwd_pend;
        logic so, so_oe, g0_out, g0_oe, serial_tx, tx_valid;
        logic [7:0] tx_head, pa;
    } rft_dev_t;

    rft_dev_t r, n;

    // status byte: ready bit, state, saturated count
    function automatic logic [7:0] status_byte(rft_radio_t st, logic rw, logic [6:0] txc, logic [6:0] rxc);
        logic [6:0] c;
        c = rw ? rxc : 7'(RFT_FIFO_DEPTH) - txc;
        if (c > RFT_STAT_SAT) begin
            c = RFT_STAT_SAT;
        end
        return {1'b0, st, c[3:0]};
    endfunction

    // whole next-state computation
    always_comb begin
        logic cs_fall, cs_rise, ck_rise, ck_fall, tx_push, tx_pop, rx_push, rx_pop, fl_tx, fl_rx;
        logic [7:0] byte_in, nxt;
        rft_stb_t stb;
        n = r;
        cs_fall = 1'b0;
        cs_rise = 1'b0;
        ck_rise = 1'b0;
        ck_fall = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        fl_tx = 1'b0;
        fl_rx = 1'b0;
        byte_in = {r.sin[6:0], r.si_s2};
        nxt = 8'h00;
        stb = RFT_S_NONE;
        // pin synchronisers
        n.cs_s1 = LINK.chip_select_n;
        n.cs_s2 = r.cs_s1;
        n.cs_q = r.cs_s2;
        n.ck_s1 = LINK.sclk;
        n.ck_s2 = r.ck_s1;
        n.ck_q = r.ck_s2;
        n.si_s1 = LINK.si;
        n.si_s2 = r.si_s1;
        n.g0_s1 = LINK.gen0_line;
        n.g0_s2 = r.g0_s1;
        cs_fall = r.cs_q & ~r.cs_s2;
        cs_rise = ~r.cs_q & r.cs_s2;
        ck_rise = ~r.cs_s2 & ~r.ck_q & r.ck_s2;
        ck_fall = ~r.cs_s2 & r.ck_q & ~r.ck_s2;
        // deselected: back to header, index to zero
        if (r.cs_s2) begin
            n.mode = RFT_M_HDR;
            n.bit_cnt = 3'h0;
            n.idx = '0;
            n.load_pend = 1'b0;
        end
        // select falling: wake, then pin control strobe
        if (cs_fall) begin
            n.sout = 8'h00;
            if (r.radio == RFT_SLEEP) begin
                n.radio = RFT_IDLE;
            end
            if (PIN_CONTROL_ENABLE) begin
                unique case ({r.ck_s2, r.si_s2})
                    2'b00: stb = RFT_S_PWD;
                    2'b01: stb = RFT_S_TX;
                    2'b10: stb = RFT_S_IDLE;
                    2'b11: stb = RFT_S_RX;
                endcase
            end
        end
        // serial clock rising: shift in, act on complete bytes
        if (ck_rise) begin
            n.sin = byte_in;
            n.bit_cnt = r.bit_cnt + 3'h1;
            if (r.mode == RFT_M_HDR && r.bit_cnt == 3'h0) begin
                n.sout = status_byte(r.radio, r.si_s2, r.tx_cnt, r.rx_cnt);
            end
            if (r.bit_cnt == 3'h7) begin
                n.load_pend = 1'b1;
                unique case (r.mode)
                    RFT_M_HDR: begin
                        n.hdr_rw = byte_in[RFT_HDR_RW];
                        n.burst = byte_in[RFT_HDR_BURST];
                        n.mode = RFT_M_SKIP;
                        if (byte_in[5:0] == RFT_ADDR_FIFO) begin
                            n.mode = byte_in[RFT_HDR_RW] ? RFT_M_RXR : RFT_M_TXW;
                        end else if (byte_in[5:0] == RFT_ADDR_TABLE) begin
                            n.mode = byte_in[RFT_HDR_RW] ? RFT_M_TBLR : RFT_M_TBLW;
                        end else if (!byte_in[RFT_HDR_BURST] && byte_in[5:4] == 2'h3 && byte_in[3:0] <= 4'hd) begin
                            n.mode = RFT_M_HDR;
                            unique case (byte_in[5:0])
                                RFT_ADDR_RX: stb = RFT_S_RX;
                                RFT_ADDR_TX: stb = RFT_S_TX;
                                RFT_ADDR_IDLE: stb = RFT_S_IDLE;
                                RFT_ADDR_PWD: stb = RFT_S_PWD;
                                RFT_ADDR_FRX: stb = RFT_S_FRX;
                                RFT_ADDR_FTX: stb = RFT_S_FTX;
                                default: stb = RFT_S_NONE;
                            endcase
                        end
                    end
                    RFT_M_TXW: begin
                        if (r.tx_cnt != 7'(RFT_FIFO_DEPTH)) begin
                            tx_push = 1'b1;
                        end
                    end
                    RFT_M_TBLW: begin
                        n.power_amp_table[r.idx] = byte_in;
                        n.idx = r.idx + 3'h1;
                    end
                    RFT_M_TBLR: n.idx = r.idx + 3'h1;
                    default: n.mode = r.mode;
                endcase
                if (r.mode != RFT_M_HDR && !r.burst) begin
                    n.mode = RFT_M_HDR;
                end
            end
        end
        // serial clock falling: shift out or load the next byte
        if (ck_fall) begin
            if (r.load_pend) begin
                n.load_pend = 1'b0;
                unique case (r.mode)
                    RFT_M_TXW, RFT_M_TBLW: nxt = status_byte(r.radio, 1'b0, r.tx_cnt, r.rx_cnt);
                    RFT_M_SKIP: nxt = status_byte(r.radio, r.hdr_rw, r.tx_cnt, r.rx_cnt);
                    RFT_M_TBLR: nxt = r.power_amp_table[r.idx];
                    RFT_M_RXR: begin
                        if (r.rx_cnt != '0) begin
                            nxt = r.rx_mem[r.rx_rd];
                            rx_pop = 1'b1;
                        end
                    end
                    default: nxt = 8'h00;
                endcase
                n.sout = nxt;
            end else begin
                n.sout = {r.sout[6:0], 1'b0};
            end
        end
        // modem side: underrun and overrun
        if (TX_POP && r.radio == RFT_TX) begin
            if (r.tx_cnt != '0) begin
                tx_pop = 1'b1;
            end else begin
                n.radio = RFT_TXUNF;
            end
        end
        if (RX_PUSH && r.radio == RFT_RX) begin
            if (r.rx_cnt != 7'(RFT_FIFO_DEPTH)) begin
                rx_push = 1'b1;
            end else begin
                n.radio = RFT_RXOVF;
            end
        end
        // apply strobes; state changes and fifo flushes
        unique case (stb)
            RFT_S_RX: if (n.radio == RFT_IDLE || n.radio == RFT_TX) n.radio = RFT_RX;
            RFT_S_TX: if (n.radio == RFT_IDLE || n.radio == RFT_RX) n.radio = RFT_TX;
            RFT_S_IDLE: if (n.radio != RFT_SLEEP) n.radio = RFT_IDLE;
            RFT_S_PWD: n.pwd_pend = 1'b1;
            RFT_S_FRX, RFT_S_FTX: begin
                if (n.radio == RFT_IDLE || n.radio == RFT_RXOVF || n.radio == RFT_TXUNF) begin
                    fl_rx = (stb == RFT_S_FRX);
                    fl_tx = (stb == RFT_S_FTX);
                    // judged on the old state, so an error raised in this same cycle survives the flush
                    if ((fl_rx && r.radio == RFT_RXOVF) || (fl_tx && r.radio == RFT_TXUNF)) begin
                        n.radio = RFT_IDLE;
                    end
                end
            end
            default: n.radio = n.radio;
        endcase
        // delayed power down on select high
        if (cs_rise && r.pwd_pend) begin
            n.pwd_pend = 1'b0;
            n.radio = RFT_SLEEP;
            fl_tx = 1'b1;
            fl_rx = 1'b1;
            for (int i = 1; i < 8; i++) begin
                n.power_amp_table[i] = 8'h00;
            end
        end
        // fifo pointers and counts
        if (tx_push) begin
            n.tx_mem[r.tx_wr] = byte_in;
            n.tx_wr = r.tx_wr + 6'h1;
        end
        if (tx_pop) begin
            n.tx_rd = r.tx_rd + 6'h1;
        end
        n.tx_cnt = r.tx_cnt + 7'(tx_push) - 7'(tx_pop);
        if (rx_push) begin
            n.rx_mem[r.rx_wr] = RX_DATA;
            n.rx_wr = r.rx_wr + 6'h1;
        end
        if (rx_pop) begin
            n.rx_rd = r.rx_rd + 6'h1;
        end
        n.rx_cnt = r.rx_cnt + 7'(rx_push) - 7'(rx_pop);
        if (fl_tx) begin
            n.tx_wr = '0;
            n.tx_rd = '0;
            n.tx_cnt = '0;
        end
        if (fl_rx) begin
            n.rx_wr = '0;
            n.rx_rd = '0;
            n.rx_cnt = '0;
        end
        // pins and registered outputs
        n.so_oe = ~r.cs_s2 | SO_GENERAL_ENABLE;
        n.so = r.cs_s2 ? SO_GENERAL_LEVEL : n.sout[7];
        n.g0_oe = ~(SERIAL_MODE && r.radio == RFT_TX);
        n.g0_out = GEN0_LEVEL;
        n.serial_tx = r.g0_s2;
        n.tx_head = n.tx_mem[n.tx_rd];
        n.tx_valid = (n.tx_cnt != '0);
        n.pa = n.power_amp_table[POWER_LEVEL_SELECT];
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            r <= '0;
            r.cs_s1 <= 1'b1;
            r.cs_s2 <= 1'b1;
            r.cs_q <= 1'b1;
            r.radio <= RFT_IDLE;
            r.mode <= RFT_M_HDR;
            r.g0_oe <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign LINK.so = r.so;
    assign LINK.so_oe = r.so_oe;
    assign LINK.gen0_dev = r.g0_out;
    assign LINK.gen0_dev_oe = r.g0_oe;
    assign TX_DATA = r.tx_head;
    assign TX_VALID = r.tx_valid;
    assign PA_SETTING = r.pa;
    assign RADIO_STATE = r.radio;
    assign SERIAL_TX_DATA = r.serial_tx;
endmodule
`default_nettype wire

// *** include/rft_pkg.sv ***
`default_nettype none
package rft_pkg;
    // fifo and table geometry
    localparam int RFT_FIFO_DEPTH = 64;
    localparam int RFT_FIFO_AW = 6;
    localparam int RFT_TABLE_AW = 3;
    // header byte layout
    localparam int RFT_HDR_RW = 7;
    localparam int RFT_HDR_BURST = 6;
    localparam logic [5:0] RFT_ADDR_TABLE = 6'h3e;
    localparam logic [5:0] RFT_ADDR_FIFO = 6'h3f;
    // strobe addresses, single access only
    localparam logic [5:0] RFT_ADDR_RX = 6'h30;
    localparam logic [5:0] RFT_ADDR_TX = 6'h31;
    localparam logic [5:0] RFT_ADDR_IDLE = 6'h32;
    localparam logic [5:0] RFT_ADDR_PWD = 6'h33;
    localparam logic [5:0] RFT_ADDR_FRX = 6'h34;
    localparam logic [5:0] RFT_ADDR_FTX = 6'h35;
    // status byte count saturation
    localparam logic [6:0] RFT_STAT_SAT = 7'h0f;
    // host serial clock timing
    localparam int RFT_CLK_PS = 5000;
    localparam int RFT_SCLK_HALF_PS = 50000;
    localparam int RFT_HALF_CYC = (RFT_SCLK_HALF_PS + RFT_CLK_PS - 1) / RFT_CLK_PS;
    // host register map
    localparam logic [7:0] RFT_REG_CTRL = 8'h00;
    localparam logic [7:0] RFT_REG_XFER = 8'h04;
    localparam logic [7:0] RFT_REG_STAT = 8'h08;
    localparam logic [3:0] RFT_CTRL_RESET = 4'h0;
    localparam int RFT_CTRL_SCLK = 0;
    localparam int RFT_CTRL_SI = 1;
    localparam int RFT_CTRL_G0_OE = 2;
    localparam int RFT_CTRL_G0_LVL = 3;
    localparam int RFT_XFER_RELEASE = 8;
    localparam int RFT_STAT_BUSY = 8;
    localparam int RFT_STAT_CS = 9;
    localparam int RFT_STAT_G0 = 10;
    localparam logic [1:0] RFT_HTRANS_NONSEQ = 2'h2;
    // radio main states, code reported in status bits 6:4
    typedef enum logic [2:0] {
        RFT_IDLE = 3'b000,
        RFT_RX = 3'b001,
        RFT_TX = 3'b010,
        RFT_SLEEP = 3'b100,
        RFT_RXOVF = 3'b110,
        RFT_TXUNF = 3'b111
    } rft_radio_t;
    // what the next serial byte means
    typedef enum logic [2:0] {
        RFT_M_HDR = 3'b000,
        RFT_M_TXW = 3'b001,
        RFT_M_RXR = 3'b010,
        RFT_M_TBLW = 3'b011,
        RFT_M_TBLR = 3'b100,
        RFT_M_SKIP = 3'b101
    } rft_mode_t;
    // internal command strobes
    typedef enum logic [2:0] {
        RFT_S_NONE = 3'b000,
        RFT_S_RX = 3'b001,
        RFT_S_TX = 3'b010,
        RFT_S_IDLE = 3'b011,
        RFT_S_PWD = 3'b100,
        RFT_S_FRX = 3'b101,
        RFT_S_FTX = 3'b110
    } rft_stb_t;
    // host serial engine phases
    typedef enum logic [2:0] {
        RFT_H_IDLE = 3'b000,
        RFT_H_SETUP = 3'b001,
        RFT_H_LOW = 3'b010,
        RFT_H_HIGH = 3'b011,
        RFT_H_HOLD = 3'b100,
        RFT_H_GAP = 3'b101
    } rft_hphase_t;
endpackage
`default_nettype wire

// *** include/rft_link_if.sv ***
`default_nettype none
interface rft_link_if;
    logic chip_select_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic gen0_host;
    logic gen0_host_oe;
    logic gen0_dev;
    logic gen0_dev_oe;
    logic so_line;
    logic gen0_line;
    // resolved pin levels, pulled high when undriven
    assign so_line = so_oe ? so : 1'b1;
    assign gen0_line = gen0_dev_oe ? gen0_dev : (gen0_host_oe ? gen0_host : 1'b1);
    modport dev (input chip_select_n, sclk, si, gen0_line, output so, so_oe, gen0_dev, gen0_dev_oe);
    modport host (output chip_select_n, sclk, si, gen0_host, gen0_host_oe, input so_line, gen0_line);
endinterface
`default_nettype wire

// *** core/rft_host.sv ***
`default_nettype none
module rft_host
    import rft_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // serial link
    rft_link_if.host LINK,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    typedef struct packed {
        logic so_s1, so_s2, g0_s1, g0_s2;
        logic cs_n, sclk, si;
        logic [3:0] ctrl;
        rft_hphase_t ph;
        logic [7:0] tx, rx, rx_byte;
        logic release_cs;
        logic [2:0] bit_cnt;
        logic [7:0] tmr;
        logic pend, pend_wr;
        logic [7:0] pend_addr;
        logic hready, hresp;
        logic [31:0] hrdata;
    } rft_host_t;

    rft_host_t r, n;

    // serial engine and register slave
    always_comb begin
        logic tick;
        n = r;
        n.so_s1 = LINK.so_line;
        n.so_s2 = r.so_s1;
        n.g0_s1 = LINK.gen0_line;
        n.g0_s2 = r.g0_s1;
        n.hresp = 1'b0;
        tick = (r.tmr == 8'h00);
        n.tmr = tick ? 8'(RFT_HALF_CYC - 1) : r.tmr - 8'h01;
        // levels for pin control while deselected
        if (r.ph == RFT_H_IDLE && r.cs_n) begin
            n.sclk = r.ctrl[RFT_CTRL_SCLK];
            n.si = r.ctrl[RFT_CTRL_SI];
        end
        unique case (r.ph)
            RFT_H_IDLE: n.tmr = 8'(RFT_HALF_CYC - 1);
            RFT_H_SETUP: if (tick) begin
                n.ph = RFT_H_LOW;
                n.sclk = 1'b0;
                n.si = r.tx[7];
            end
            RFT_H_LOW: if (tick) begin
                n.ph = RFT_H_HIGH;
                n.sclk = 1'b1;
                n.rx = {r.rx[6:0], r.so_s2};
            end
            RFT_H_HIGH: if (tick) begin
                n.sclk = 1'b0;
                n.bit_cnt = r.bit_cnt + 3'h1;
                n.tx = {r.tx[6:0], 1'b0};
                n.si = r.tx[6];
                n.ph = RFT_H_LOW;
                if (r.bit_cnt == 3'h7) begin
                    n.rx_byte = r.rx;
                    n.ph = r.release_cs ? RFT_H_HOLD : RFT_H_IDLE;
                end
            end
            RFT_H_HOLD: if (tick) begin
                n.cs_n = 1'b1;
                n.ph = RFT_H_GAP;
            end
            RFT_H_GAP: if (tick) begin
                n.ph = RFT_H_IDLE;
            end
            default: n.ph = RFT_H_IDLE;
        endcase
        // ahb address phase
        if (HSEL && HREADY && HTRANS == RFT_HTRANS_NONSEQ) begin
            n.pend = 1'b1;
            n.pend_wr = HWRITE;
            n.pend_addr = HADDR[7:0];
            n.hready = 1'b0;
        end else if (r.pend && !(r.pend_wr && r.pend_addr == RFT_REG_XFER && r.ph != RFT_H_IDLE)) begin
            // data phase, a transfer write stalled while a byte is in flight
            n.pend = 1'b0;
            n.hready = 1'b1;
            n.hrdata = 32'h0;
            if (r.pend_wr) begin
                if (r.pend_addr == RFT_REG_CTRL) begin
                    n.ctrl = HWDATA[3:0];
                end else if (r.pend_addr == RFT_REG_XFER) begin
                    n.tx = HWDATA[7:0];
                    n.release_cs = HWDATA[RFT_XFER_RELEASE];
                    n.bit_cnt = 3'h0;
                    n.cs_n = 1'b0;
                    n.ph = RFT_H_SETUP;
                    n.tmr = 8'(RFT_HALF_CYC - 1);
                end
            end else if (r.pend_addr == RFT_REG_CTRL) begin
                n.hrdata = {28'h0, r.ctrl};
            end else if (r.pend_addr == RFT_REG_STAT) begin
                n.hrdata = {21'h0, r.g0_s2, ~r.cs_n, r.ph != RFT_H_IDLE, r.rx_byte};
            end
        end
    end

    // state register
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            r <= '0;
            r.cs_n <= 1'b1;
            r.ctrl <= RFT_CTRL_RESET;
            r.ph <= RFT_H_IDLE;
            r.hready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign LINK.chip_select_n = r.cs_n;
    assign LINK.sclk = r.sclk;
    assign LINK.si = r.si;
    assign LINK.gen0_host = r.ctrl[RFT_CTRL_G0_LVL];
    assign LINK.gen0_host_oe = r.ctrl[RFT_CTRL_G0_OE];
    assign HRDATA = r.hrdata;
    assign HREADYOUT = r.hready;
    assign HRESP = r.hresp;
endmodule
`default_nettype wire

// *** verif/rft_chk.sv ***
`default_nettype none
module rft_chk (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // link pins
    input wire logic chip_select_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns / 1ps;
    logic [2:0] bits;
    logic sclk_q;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // bit clocks counted in the open frame
    always_ff @(posedge CLOCK) begin
        sclk_q <= sclk;
        bits <= (!RSTN || chip_select_n) ? 3'h0 : bits + 3'(sclk && !sclk_q);
    end
    // bit clock edges inside a frame
    sequence s_rise; $rose(sclk) && !chip_select_n; endsequence
    sequence s_fall; $fell(sclk) && !chip_select_n; endsequence
    // framing, bit clock and data timing
    property p_bytes; $rose(chip_select_n) |-> bits == 3'h0; endproperty
    property p_gap; $rose(chip_select_n) |-> chip_select_n [*8]; endproperty
    property p_high; s_rise |-> sclk [*8]; endproperty
    property p_low; s_fall |-> (!sclk) [*8]; endproperty
    property p_si; s_rise |=> $stable(si) [*8]; endproperty
    property p_so; s_rise |=> $stable(so) [*8]; endproperty
    property p_on; $fell(chip_select_n) |-> ##[1:8] so_oe; endproperty
    property p_off; $rose(chip_select_n) |-> ##[1:8] !so_oe; endproperty
    a_bytes: assert property (p_bytes) else $error("frame ends inside a byte");
    a_gap: assert property (p_gap) else $error("select high too short");
    a_high: assert property (p_high) else $error("bit clock high too short");
    a_low: assert property (p_low) else $error("bit clock low too short");
    a_si: assert property (p_si) else $error("si moved while clock high");
    a_so: assert property (p_so) else $error("so moved while clock high");
    a_on: assert property (p_on) else $error("so not driven when selected");
    a_off: assert property (p_off) else $error("so still driven when deselected");
endmodule
`default_nettype wire

// *** verif/tb_radio_fifo_table_host_access.sv ***
`default_nettype none
module tb_radio_fifo_table_host_access
    import rft_pkg::*;
;
    timeunit 1ns / 1ps;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pce = 1'b0, smode = 1'b0, pop = 1'b0, pu = 1'b0;
    logic hready, hresp, txv, transmit_strobe;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [7:0] rxd = 8'h0, txd, pa;
    logic [2:0] psel = 3'h0, st;
    logic [3:0] ctl [5] = '{4'h2, 4'h3, 4'h1, 4'h0, 4'h1};
    logic [7:0] pst [5] = '{8'h02, 8'h01, 8'h00, 8'h04, 8'h00};
    int err_total = 0, checked = 0;
    rft_link_if link();
    // 200 mhz clock
    always #2.5 clk = ~clk;
    // both ends and the link checker
    rft_host i_rft_host (.CLOCK(clk), .RSTN(rstn), .LINK(link.host), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp));
    rft_dev i_rft_dev (.CLOCK(clk), .RSTN(rstn), .LINK(link.dev), .PIN_CONTROL_ENABLE(pce), .SO_GENERAL_ENABLE(1'b0),
        .SO_GENERAL_LEVEL(1'b0), .SERIAL_MODE(smode), .GEN0_LEVEL(1'b1), .POWER_LEVEL_SELECT(psel), .TX_POP(pop),
        .RX_PUSH(pu), .RX_DATA(rxd), .TX_DATA(txd), .TX_VALID(txv), .PA_SETTING(pa), .RADIO_STATE(st),
        .SERIAL_TX_DATA(transmit_strobe));
    rft_chk i_rft_chk (.CLOCK(clk), .RSTN(rstn), .chip_select_n(link.chip_select_n), .sclk(link.sclk),
        .si(link.si), .so(link.so), .so_oe(link.so_oe));
    // compare and count
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single word bus transfer
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= RFT_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
        chk("hresp", 8'h00, {7'h0, hresp});
    endtask
    // one link byte, compare the byte seen on so
    task automatic xb(input logic [7:0] b, input logic rel, input logic [8:0] e);
        bus(RFT_REG_XFER, 1'b1, {23'h0, rel, b});
        do bus(RFT_REG_STAT, 1'b0, 32'h0); while (r[RFT_STAT_BUSY] !== 1'b0);
        if (!e[8]) chk("link byte", e[7:0], r[7:0]);
    endtask
    // modem side receive bytes, one per clock
    task automatic push(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++) begin
            pu <= 1'b1;
            rxd <= b0 + 8'(i);
            @(posedge clk);
        end
        pu <= 1'b0;
        // let the last push settle before anyone looks at the state
        @(posedge clk);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        end_sim;
    end
    // test sequence
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        bus(8'h0c, 1'b1, 32'hffffffff);
        bus(8'h0c, 1'b0, 32'h0);
        chk("unmapped", 8'h00, r[7:0]);
        bus(RFT_REG_CTRL, 1'b0, 32'h0);
        chk("ctrl", 8'(RFT_CTRL_RESET), r[7:0]);
        $display("done registers");
        xb(8'h3f, '0, 9'h00f);
        xb(8'ha5, '0, 9'h00f);
        xb(8'h7f, '0, 9'h00f);
        for (int i = 0; i < 64; i++) xb(8'(i), i == 63, (i < 48) ? 9'h00f : 9'(63 - i));
        chk("tx head", 8'ha5, txd);
        xb(8'h35, '1, 9'h000);
        chk("tx valid", 8'h00, 8'(txv));
        $display("done tx fifo");
        xb(8'h30, '1, 9'h00f);
        chk("state", 8'h01, 8'(st));
        push(3, 8'hc0);
        xb(8'hbf, '0, 9'h013);
        xb(8'h00, '0, 9'h0c0);
        xb(8'hff, '0, 9'h012);
        xb(8'h00, '0, 9'h0c1);
        xb(8'h00, '1, 9'h0c2);
        push(65, 8'h00);
        chk("state", 8'h06, 8'(st));
        xb(8'h34, '1, 9'h06f);
        chk("state", 8'h00, 8'(st));
        $display("done rx fifo");
        xb(8'h7e, '0, 9'h00f);
        for (int i = 0; i < 9; i++) xb(8'h10 + 8'(i), i == 8, 9'h00f);
        for (int i = 0; i < 8; i++) begin
            psel <= 3'(i);
            repeat (3) @(posedge clk);
            chk("table", (i == 0) ? 8'h18 : 8'h10 + 8'(i), pa);
        end
        xb(8'hfe, '0, 9'h000);
        for (int i = 0; i < 8; i++) xb(8'h00, i == 7, (i == 0) ? 9'h018 : 9'h010 + 9'(i));
        xb(8'h3e, '0, 9'h00f);
        xb(8'h55, '0, 9'h00f);
        xb(8'hbe, '0, 9'h000);
        xb(8'h00, '1, 9'h011);
        xb(8'hbe, '0, 9'h000);
        xb(8'h00, '1, 9'h055);
        $display("done table");
        xb(8'h3f, '0, 9'h00f);
        xb(8'h77, '0, 9'h00f);
        xb(8'h33, '1, 9'h00f);
        repeat (20) @(posedge clk);
        chk("state", 8'h04, 8'(st));
        chk("tx valid", 8'h00, 8'(txv));
        psel <= 3'h1;
        repeat (3) @(posedge clk);
        chk("table", 8'h00, pa);
        psel <= 3'h0;
        repeat (3) @(posedge clk);
        chk("table", 8'h55, pa);
        xb(8'h3d, '1, 9'h100);
        chk("state", 8'h00, 8'(st));
        $display("done sleep");
        pce <= 1'b1;
        smode <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus(RFT_REG_CTRL, 1'b1, {28'h0, ctl[i]});
            xb(8'h3d, '1, 9'h100);
            repeat (20) @(posedge clk);
            chk("pin state", pst[i], 8'(st));
        end
        bus(RFT_REG_CTRL, 1'b1, 32'h6);
        xb(8'h3d, '1, 9'h100);
        repeat (20) @(posedge clk);
        chk("serial tx", 8'h00, 8'(transmit_strobe));
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
        repeat (3) @(posedge clk);
        chk("state", 8'h07, 8'(st));
        pce <= 1'b0;
        bus(RFT_REG_CTRL, 1'b1, 32'h0);
        xb(8'h35, '1, 9'h07f);
        chk("state", 8'h00, 8'(st));
        $display("done pin control");
        end_sim;
    end
endmodule
`default_nettype wire
